//--- design/pifb_defines.vh
// constants for the peripheral interrupt flag bank
`ifndef PIFB_DEFINES_VH
`define PIFB_DEFINES_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define PIFB_OFF_FLAGS_ONE 8'h00
`define PIFB_OFF_FLAGS_TWO 8'h04
`define PIFB_OFF_FLAGS_THREE 8'h08
`define PIFB_OFF_FLAGS_FOUR 8'h0c
`define PIFB_OFF_ENABLES_ONE 8'h10
`define PIFB_OFF_ENABLES_TWO 8'h14
`define PIFB_OFF_ENABLES_THREE 8'h18
`define PIFB_OFF_ENABLES_FOUR 8'h1c
`define PIFB_OFF_GLOBAL_CTRL 8'h20
`define PIFB_OFF_IRQ_STATUS 8'h24
`define PIFB_OFF_IRQ_MASK 8'h28

// ************************************************************
// implemented and writable bit masks
// ************************************************************
`define PIFB_MASK_ONE 8'hff
`define PIFB_WRMASK_ONE 8'hcf
`define PIFB_MASK_TWO_LARGE 8'hf9
`define PIFB_MASK_TWO_SMALL 8'hf8
`define PIFB_MASK_THREE 8'h3a
`define PIFB_MASK_FOUR 8'h03
`define PIFB_MASK_GCTL 8'hc0
`define PIFB_MASK_STATUS 8'h1f

// ************************************************************
// field positions
// ************************************************************
`define PIFB_BIT_GLOBAL_EN 7
`define PIFB_BIT_PERIPH_EN 6
`define PIFB_STAT_REQ_RISE 4

// ************************************************************
// reset values and padding
// ************************************************************
`define PIFB_RST_BYTE 8'h00
`define PIFB_PAD_ZERO 24'h000000
`define PIFB_BYTE_ZERO 8'h00

`endif

//--- design/pifb_flag_reg.v
// one eight-bit request flag register, hardware set and software write
module pifb_flag_reg #(
    parameter [7:0] IMPL_MASK = 8'hff,
    parameter [7:0] WR_MASK = 8'hff
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // hardware condition pulses
    input wire [7:0] hw_set,
    // software write
    input wire wr_en,
    input wire [7:0] wdata,
    // state
    output wire [7:0] flags,
    output wire set_seen
);
`include "pifb_defines.vh"

    wire [7:0] flag_q;

    // one sticky flag per bit; hardware set wins over a software clear
    // each bit keeps its own flop so the vector has a single driver
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            if (IMPL_MASK[i]) begin : g_impl
                reg bit_q;
                always @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        bit_q <= 1'b0;
                    end else if (hw_set[i]) begin
                        bit_q <= 1'b1;
                    end else if (wr_en && WR_MASK[i]) begin
                        bit_q <= wdata[i];
                    end
                end
                assign flag_q[i] = bit_q;
            end else begin : g_none
                // absent bit: no storage, reads zero, writes dropped
                assign flag_q[i] = 1'b0;
            end
        end
    endgenerate

    assign flags = flag_q;
    assign set_seen = |(hw_set & IMPL_MASK);
endmodule

//--- design/pifb_apb_if.v
// apb slave handshake for the flag bank, zero wait states
module pifb_apb_if (
    // apb request
    input wire psel,
    input wire penable,
    input wire pwrite,
    // decode result from the register file
    input wire addr_hit,
    // apb answer
    output wire pready,
    output wire pslverr,
    // strobes to the register file
    output wire setup_rd,
    output wire wr_stb,
    output wire rd_stb
);

    wire access;

    // every access completes in its first access cycle
    assign access = psel & penable;
    assign pready = access;
    assign pslverr = access & ~addr_hit;
    // read data is captured in the setup cycle so prdata is a flop
    assign setup_rd = psel & ~penable & ~pwrite;
    // unmapped addresses neither store nor clear anything
    assign wr_stb = access & pwrite & addr_hit;
    assign rd_stb = access & ~pwrite & addr_hit;
endmodule

//--- design/pifb_bank.v
// peripheral interrupt flag bank with enables, global control and apb access
// Notes on behaviour
// - a flag sets on its condition regardless of any enable bit
// - a flag reads one while pending and zero otherwise
// - flags two: osc fail 7, comparators 6 5, nvm 4, collision 3, capcomp 0
// - flags three: capcomp four 5, three 4, timer six 3, timer four 1
// - unimplemented bits read zero and ignore writes
// - flags four bit 1: serial two collision, hardware set, software clear
// - flags four bit 0: serial two done, hardware set, software clear
// - every implemented flag resets to zero on any reset
// - flags three, four and capcomp two exist only in the large variant
// - an enable bit of one passes its flag, zero blocks it
// - no core request unless the peripheral enable bit is set
module pifb_bank #(
    parameter LARGE_VARIANT = 1
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // first flag register conditions, one pulse per bit
    input wire [7:0] flags_one_events,
    // second flag register conditions
    input wire osc_fail_event,
    input wire comparator_two_event,
    input wire comparator_one_event,
    input wire nvm_write_done_event,
    input wire serial_one_collision_event,
    input wire capcomp_two_event,
    // third flag register conditions
    input wire capcomp_four_event,
    input wire capcomp_three_event,
    input wire timer_six_match_event,
    input wire timer_four_match_event,
    // fourth flag register conditions
    input wire serial_two_collision_event,
    input wire serial_two_done_event,
    // requests out
    output reg core_irq_req,
    output wire bank_irq
);
`include "pifb_defines.vh"

    // ************************************************************
    // variant dependent masks
    // ************************************************************
    // the small variant drops the capcomp two flag and the upper banks
    localparam [7:0] MASK_TWO = (LARGE_VARIANT != 0) ?
        `PIFB_MASK_TWO_LARGE : `PIFB_MASK_TWO_SMALL;
    localparam [7:0] MASK_THREE = (LARGE_VARIANT != 0) ?
        `PIFB_MASK_THREE : `PIFB_BYTE_ZERO;
    localparam [7:0] MASK_FOUR = (LARGE_VARIANT != 0) ?
        `PIFB_MASK_FOUR : `PIFB_BYTE_ZERO;

    // ************************************************************
    // declarations
    // ************************************************************
    wire setup_rd;
    wire wr_stb;
    wire rd_stb;
    reg addr_hit;
    reg [7:0] read_byte;
    wire [7:0] wbyte;

    wire [7:0] set_two;
    wire [7:0] set_three;
    wire [7:0] set_four;

    wire [7:0] flags_one;
    wire [7:0] flags_two;
    wire [7:0] flags_three;
    wire [7:0] flags_four;
    wire seen_one;
    wire seen_two;
    wire seen_three;
    wire seen_four;

    reg [7:0] enables_one;
    reg [7:0] enables_two;
    reg [7:0] enables_three;
    reg [7:0] enables_four;
    reg [7:0] global_ctrl;
    reg [7:0] irq_status;
    reg [7:0] irq_mask;
    reg [7:0] status_clr;

    wire global_irq_enable;
    wire peripheral_irq_enable;
    wire any_pending;
    wire next_core_irq_req;
    wire [7:0] status_events;

    assign wbyte = pwdata[7:0];

    // ************************************************************
    // bus handshake
    // ************************************************************
    pifb_apb_if u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .addr_hit(addr_hit),
        .pready(pready),
        .pslverr(pslverr),
        .setup_rd(setup_rd),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb)
    );

    // ************************************************************
    // condition mapping onto bit positions
    // ************************************************************
    // second bank, bits 2 and 1 have no source
    assign set_two = {osc_fail_event,
                      comparator_two_event,
                      comparator_one_event,
                      nvm_write_done_event,
                      serial_one_collision_event,
                      2'b00,
                      capcomp_two_event};
    // third bank, bits 7, 6, 2 and 0 have no source
    assign set_three = {2'b00,
                        capcomp_four_event,
                        capcomp_three_event,
                        timer_six_match_event,
                        1'b0,
                        timer_four_match_event,
                        1'b0};
    // fourth bank, collision in bit 1 and done in bit 0
    assign set_four = {6'b000000,
                       serial_two_collision_event,
                       serial_two_done_event};

    // ************************************************************
    // flag registers
    // ************************************************************
    // conditions land in the flags with no look at any enable
    pifb_flag_reg #(
        .IMPL_MASK(`PIFB_MASK_ONE),
        .WR_MASK(`PIFB_WRMASK_ONE)
    ) u_flags_one (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(flags_one_events),
        .wr_en(wr_stb && (paddr == `PIFB_OFF_FLAGS_ONE)),
        .wdata(wbyte),
        .flags(flags_one),
        .set_seen(seen_one)
    );

    pifb_flag_reg #(
        .IMPL_MASK(MASK_TWO),
        .WR_MASK(MASK_TWO)
    ) u_flags_two (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(set_two),
        .wr_en(wr_stb && (paddr == `PIFB_OFF_FLAGS_TWO)),
        .wdata(wbyte),
        .flags(flags_two),
        .set_seen(seen_two)
    );

    pifb_flag_reg #(
        .IMPL_MASK(MASK_THREE),
        .WR_MASK(MASK_THREE)
    ) u_flags_three (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(set_three),
        .wr_en(wr_stb && (paddr == `PIFB_OFF_FLAGS_THREE)),
        .wdata(wbyte),
        .flags(flags_three),
        .set_seen(seen_three)
    );

    // fourth bank: writing zero is how software acknowledges
    pifb_flag_reg #(
        .IMPL_MASK(MASK_FOUR),
        .WR_MASK(MASK_FOUR)
    ) u_flags_four (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(set_four),
        .wr_en(wr_stb && (paddr == `PIFB_OFF_FLAGS_FOUR)),
        .wdata(wbyte),
        .flags(flags_four),
        .set_seen(seen_four)
    );

    // ************************************************************
    // enable, control and mask registers
    // ************************************************************
    // reset clears every enable so no stale flag fires at boot
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables_one <= `PIFB_RST_BYTE;
            enables_two <= `PIFB_RST_BYTE;
            enables_three <= `PIFB_RST_BYTE;
            enables_four <= `PIFB_RST_BYTE;
            global_ctrl <= `PIFB_RST_BYTE;
            irq_mask <= `PIFB_RST_BYTE;
        end else if (wr_stb) begin
            case (paddr)
                `PIFB_OFF_ENABLES_ONE: begin
                    enables_one <= wbyte;
                end
                `PIFB_OFF_ENABLES_TWO: begin
                    enables_two <= wbyte & MASK_TWO;
                end
                `PIFB_OFF_ENABLES_THREE: begin
                    enables_three <= wbyte & MASK_THREE;
                end
                `PIFB_OFF_ENABLES_FOUR: begin
                    enables_four <= wbyte & MASK_FOUR;
                end
                `PIFB_OFF_GLOBAL_CTRL: begin
                    global_ctrl <= wbyte & `PIFB_MASK_GCTL;
                end
                `PIFB_OFF_IRQ_MASK: begin
                    irq_mask <= wbyte & `PIFB_MASK_STATUS;
                end
                default: begin
                    enables_one <= enables_one;
                end
            endcase
        end
    end

    // ************************************************************
    // request to the core
    // ************************************************************
    assign global_irq_enable = global_ctrl[`PIFB_BIT_GLOBAL_EN];
    assign peripheral_irq_enable = global_ctrl[`PIFB_BIT_PERIPH_EN];

    // each flag passes only where its own enable bit is one
    assign any_pending = |(flags_one & enables_one) |
                         |(flags_two & enables_two) |
                         |(flags_three & enables_three) |
                         |(flags_four & enables_four);

    // every source here is a peripheral, so both gates apply
    assign next_core_irq_req = any_pending &
                               peripheral_irq_enable &
                               global_irq_enable;

    // registered so the core sees a glitch free level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_irq_req <= 1'b0;
        end else begin
            core_irq_req <= next_core_irq_req;
        end
    end

    // ************************************************************
    // bank event status, cleared by reading it
    // ************************************************************
    // one bit per bank that saw a condition, plus request rise
    assign status_events = {3'b000,
                            next_core_irq_req & ~core_irq_req,
                            seen_four,
                            seen_three,
                            seen_two,
                            seen_one};

    // only bits already returned to software are cleared, so an
    // event landing between setup and access is kept
    always @* begin
        status_clr = `PIFB_BYTE_ZERO;
        if (rd_stb && (paddr == `PIFB_OFF_IRQ_STATUS)) begin
            status_clr = prdata[7:0];
        end
    end

    // set wins over the read clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= `PIFB_RST_BYTE;
        end else begin
            irq_status <= ((irq_status & ~status_clr) | status_events) &
                          `PIFB_MASK_STATUS;
        end
    end

    assign bank_irq = |(irq_status & irq_mask);

    // ************************************************************
    // address decode and read mux
    // ************************************************************
    // absent registers of the small variant answer as unmapped
    always @* begin
        addr_hit = 1'b1;
        read_byte = `PIFB_BYTE_ZERO;
        case (paddr)
            `PIFB_OFF_FLAGS_ONE: begin
                read_byte = flags_one;
            end
            `PIFB_OFF_FLAGS_TWO: begin
                read_byte = flags_two & MASK_TWO;
            end
            `PIFB_OFF_FLAGS_THREE: begin
                read_byte = flags_three & MASK_THREE;
                addr_hit = (LARGE_VARIANT != 0);
            end
            `PIFB_OFF_FLAGS_FOUR: begin
                read_byte = flags_four & MASK_FOUR;
                addr_hit = (LARGE_VARIANT != 0);
            end
            `PIFB_OFF_ENABLES_ONE: begin
                read_byte = enables_one;
            end
            `PIFB_OFF_ENABLES_TWO: begin
                read_byte = enables_two;
            end
            `PIFB_OFF_ENABLES_THREE: begin
                read_byte = enables_three;
                addr_hit = (LARGE_VARIANT != 0);
            end
            `PIFB_OFF_ENABLES_FOUR: begin
                read_byte = enables_four;
                addr_hit = (LARGE_VARIANT != 0);
            end
            `PIFB_OFF_GLOBAL_CTRL: begin
                read_byte = global_ctrl;
            end
            `PIFB_OFF_IRQ_STATUS: begin
                read_byte = irq_status;
            end
            `PIFB_OFF_IRQ_MASK: begin
                read_byte = irq_mask;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // read data caught in the setup cycle, held through access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= {`PIFB_PAD_ZERO, `PIFB_BYTE_ZERO};
        end else if (setup_rd) begin
            prdata <= {`PIFB_PAD_ZERO, read_byte};
        end
    end
endmodule

//--- verif/pifb_bank_properties.sv
// port assertions for the peripheral interrupt flag bank
module pifb_bank_properties (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave side
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // requests
    input wire core_irq_req,
    input wire bank_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [1:0] gsh;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_wr_to(a);
        psel && penable && pwrite && paddr == a;
    endsequence
    // shadow of both gating bits; only a completed access writes them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gsh <= 2'b00;
        end else if (psel && penable && pwrite && paddr == 8'h20) begin
            gsh <= pwdata[7:6];
        end
    end
    a_zero_wait: assert property (s_acc |-> pready)
        else $error("pready missing in access cycle");
    a_idle_quiet: assert property (!(psel && penable) |-> !pready && !pslverr)
        else $error("answer outside access cycle");
    a_unmapped_err: assert property (s_acc ##0 paddr > 8'h28 |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (s_acc ##0 paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped access");
    a_upper_zero: assert property (s_acc |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_gate_off: assert property ((gsh != 2'b11) [*2] |-> !core_irq_req)
        else $error("core request without both enables");
    a_rise_gated: assert property ($rose(core_irq_req) |-> $past(gsh) == 2'b11)
        else $error("core request rose while gated");
    a_mask_off: assert property (s_wr_to(8'h28) ##0 pwdata[4:0] == 5'h00 |=> !bank_irq)
        else $error("bank interrupt with empty mask");
    a_reset_clean: assert property ($rose(presetn) |-> !core_irq_req && !bank_irq)
        else $error("request active after reset");
endmodule

bind pifb_bank pifb_bank_properties pifb_bank_properties_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_irq_req(core_irq_req), .bank_irq(bank_irq)
);

//--- verif/pifb_periph_model.sv
// behavioural model of the peripherals that raise interrupt conditions
module pifb_periph_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // command from the bench
    input wire logic [31:0] fire,
    input wire logic slow,
    // condition lines, laid out as the flag register bits
    output logic [31:0] ev
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] stage;
    // pulses come out one or two cycles late; a slow peripheral never loses one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage <= 32'h0;
            ev <= 32'h0;
        end else begin
            stage <= slow ? fire : 32'h0;
            ev <= (slow ? 32'h0 : fire) | stage;
        end
    end
endmodule

//--- verif/pifb_bank_test.sv
// self-checking bench for the peripheral interrupt flag bank
`include "pifb_defines.vh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end

module pifb_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, fire = 32'h0, v;
    logic [3:0] st;
    wire [31:0] ev, prdata;
    wire pready, pslverr, core_irq_req, bank_irq;
    int n_mismatch = 0, total_checks = 0;
    logic [8:0] expq[$];
    logic [7:0] wm [4] = '{8'hcf, 8'hf9, 8'h3a, 8'h03};

    always #12.5 pclk = ~pclk;

    pifb_periph_model pifb_periph_model_inst (.pclk(pclk), .presetn(presetn), .fire(fire),
        .slow(slow), .ev(ev));
    pifb_bank #(.LARGE_VARIANT(1)) pifb_bank_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flags_one_events(ev[7:0]), .osc_fail_event(ev[15]), .comparator_two_event(ev[14]),
        .comparator_one_event(ev[13]), .nvm_write_done_event(ev[12]),
        .serial_one_collision_event(ev[11]), .capcomp_two_event(ev[8]),
        .capcomp_four_event(ev[21]), .capcomp_three_event(ev[20]),
        .timer_six_match_event(ev[19]), .timer_four_match_event(ev[17]),
        .serial_two_collision_event(ev[25]), .serial_two_done_event(ev[24]),
        .core_irq_req(core_irq_req), .bank_irq(bank_irq));

    // ************************************************************
    // apb master and read monitor
    // ************************************************************
    task automatic apb(input logic [7:0] a, input logic wr, input logic [7:0] d,
                       input logic [8:0] e);
        int n;
        n = 0;
        if (!wr) expq.push_back(e);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            give_verdict();
        end
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(a, 1'b1, d, 9'h000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(a, 1'b0, 8'h00, {1'b0, e});
    endtask
    task automatic pulse(input logic [31:0] p);
        fire <= p;
        @(posedge pclk);
        fire <= 32'h0;
        repeat (3) @(posedge pclk);
    endtask
    // oldest note against what the access returns, error flag included
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (expq.size() == 0) `CHK("read count", 1'b0, 1'b1)
            else `CHK("read data", expq.pop_front(), {pslverr, prdata[7:0]})
        end
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // watchdog, far above the expected few hundred cycles
    initial begin
        #200us;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'hed24));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i <= 'h28; i += 4) rd(i[7:0], 8'h00);
        apb(8'h2c, 1'b0, 8'h00, 9'h100);
        wr(8'h30, 8'hff);
        // software writes; reserved and read-only bits stay zero
        for (int k = 0; k < 4; k++) begin
            wr(8'(k * 4), 8'hff);
            rd(8'(k * 4), wm[k]);
            wr(8'(k * 4), 8'h00);
            rd(8'(k * 4), 8'h00);
        end
        // random conditions, prompt and slow, all enables off
        repeat (6) begin
            v = $urandom & 32'h033af9cf;
            slow <= 1'($urandom);
            pulse(v);
            for (int k = 0; k < 4; k++) rd(8'(k * 4), v[8 * k +: 8]);
            st = {|v[31:24], |v[23:16], |v[15:8], |v[7:0]};
            rd(8'h24, {4'h0, st});
            rd(8'h24, 8'h00);
            for (int k = 0; k < 4; k++) wr(8'(k * 4), 8'h00);
        end
        // gating chain: flags already clear before the enable is set
        slow <= 0;
        wr(8'h14, 8'h80);
        wr(8'h28, 8'h10);
        pulse(32'h00008000);
        `CHK("core request", 1'b0, core_irq_req)
        wr(8'h20, 8'h40);
        repeat (2) @(posedge pclk);
        `CHK("core request", 1'b0, core_irq_req)
        wr(8'h20, 8'hc0);
        repeat (2) @(posedge pclk);
        `CHK("core request", 1'b1, core_irq_req)
        `CHK("bank interrupt", 1'b1, bank_irq)
        rd(8'h24, 8'h12);
        `CHK("bank interrupt", 1'b0, bank_irq)
        wr(8'h14, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK("core request", 1'b0, core_irq_req)
        wr(8'h28, 8'h00);
        // condition lands on the very edge of the clearing write
        fork
            wr(8'h04, 8'h00);
            begin
                fire <= 32'h00008000;
                @(posedge pclk);
                fire <= 32'h0;
            end
        join
        rd(8'h04, 8'h80);
        // reset in mid-run drops pending flags
        pulse(32'h03000000);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(8'h0c, 8'h00);
        rd(8'h04, 8'h00);
        give_verdict();
    end
endmodule
